// File: core/lbpc_pkg.sv
// Constants for the LO buffer and PLL calibration register bank.
// Assumes an Avalon-MM slave with byte addresses and one register per word.
`default_nettype none

package lbpc_pkg;

  // Bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned BE_W = 4;
  localparam int unsigned IDX_W = 6;
  localparam int unsigned IDX_LSB = 2;
  localparam int unsigned REG_W = 8;

  // Register indices, byte address is four times the index
  localparam logic [5:0] IDX_SWING = 6'h18;
  localparam logic [5:0] IDX_CURRENT = 6'h19;
  localparam logic [5:0] IDX_BW = 6'h1a;
  localparam logic [5:0] IDX_CAL = 6'h1b;
  localparam logic [5:0] IDX_STATUS = 6'h30;

  // Field positions shared by the swing and current registers
  localparam int unsigned PRE_HI = 7;
  localparam int unsigned PRE_LO = 6;
  localparam int unsigned RX_HI = 5;
  localparam int unsigned RX_LO = 3;
  localparam int unsigned TX_HI = 2;
  localparam int unsigned TX_LO = 0;

  // Field positions of the calibration control register
  localparam int unsigned CAL_START_BIT = 7;
  localparam int unsigned CAL_DUAL_BIT = 6;
  localparam int unsigned WAIT_HI = 5;
  localparam int unsigned WAIT_LO = 4;
  localparam int unsigned CAL_RSVD_BIT = 3;
  localparam int unsigned DAC_HI = 2;
  localparam int unsigned DAC_LO = 0;

  // Status register bits
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_TGT_A_BIT = 1;
  localparam int unsigned ST_TGT_B_BIT = 2;

  // Reset values
  localparam logic [1:0] PRE_SWING_RST = 2'h3;
  localparam logic [2:0] RX_SWING_RST = 3'h4;
  localparam logic [2:0] TX_SWING_RST = 3'h1;
  localparam logic [1:0] PRE_CUR_RST = 2'h1;
  localparam logic [2:0] RX_CUR_RST = 3'h4;
  localparam logic [2:0] TX_CUR_RST = 3'h5;
  localparam logic [7:0] BW_RST = 8'h86;
  localparam logic [1:0] WAIT_RST = 2'h0;
  localparam logic [2:0] DAC_RST = 3'h5;

  // Calibration durations in reference clock periods
  localparam int unsigned CNT_W = 18;
  localparam int unsigned CAL_WAIT0_PERIODS = 90000;
  localparam int unsigned CAL_WAIT1_PERIODS = 110000;
  localparam int unsigned CAL_WAIT2_PERIODS = 130000;
  localparam int unsigned CAL_WAIT3_PERIODS = 200000;

  // Wait codes
  localparam logic [1:0] WAIT_CODE0 = 2'h0;
  localparam logic [1:0] WAIT_CODE1 = 2'h1;
  localparam logic [1:0] WAIT_CODE2 = 2'h2;

endpackage

`default_nettype wire

// File: core/lbpc_cal_timer.sv
// Calibration duration timer counting reference clock ticks.
// Assumes tick_i is a one-cycle pulse already in the core clock domain.
`default_nettype none

module lbpc_cal_timer #(
  parameter int unsigned CNT_W = 18
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic start_i,
  input wire logic tick_i,
  input wire logic [CNT_W-1:0] limit_i,
  output logic done_o
);

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] limit;
  logic running;
  logic [CNT_W-1:0] next_count;
  logic [CNT_W-1:0] next_limit;
  logic next_running;
  logic next_done;

  // Load on start, count ticks, pulse done at the limit
  always_comb begin
    next_count = count;
    next_limit = limit;
    next_running = running;
    next_done = 1'b0;
    if (start_i) begin
      next_count = '0;
      next_limit = limit_i;
      next_running = 1'b1;
    end else if (running && tick_i) begin
      if (count == limit - 1'b1) begin
        next_running = 1'b0;
        next_done = 1'b1;
      end else begin
        next_count = count + 1'b1;
      end
    end
  end

  // Timer state
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count <= '0;
      limit <= '0;
      running <= 1'b0;
      done_o <= 1'b0;
    end else if (ce_i) begin
      count <= next_count;
      limit <= next_limit;
      running <= next_running;
      done_o <= next_done;
    end
  end

endmodule

`default_nettype wire

// File: core/lbpc_regs.sv
// LO buffer, loop bandwidth and calibration control register bank.
// Assumes an Avalon-MM master on core_clk_i and a reference clock pin.
`default_nettype none

module lbpc_regs #(
  parameter int unsigned CAL_WAIT0 = lbpc_pkg::CAL_WAIT0_PERIODS,
  parameter int unsigned CAL_WAIT1 = lbpc_pkg::CAL_WAIT1_PERIODS,
  parameter int unsigned CAL_WAIT2 = lbpc_pkg::CAL_WAIT2_PERIODS,
  parameter int unsigned CAL_WAIT3 = lbpc_pkg::CAL_WAIT3_PERIODS
) (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic [lbpc_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [lbpc_pkg::DATA_W-1:0] avs_writedata_i,
  input wire logic [lbpc_pkg::BE_W-1:0] avs_byteenable_i,
  output logic [lbpc_pkg::DATA_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic ref_clk_i,
  input wire logic freq_select_i,
  output logic [1:0] pre_swing_o,
  output logic [2:0] rx_swing_o,
  output logic [2:0] tx_swing_o,
  output logic [1:0] pre_current_o,
  output logic [2:0] rx_current_o,
  output logic [2:0] tx_current_o,
  output logic [7:0] loop_bandwidth_factor_o,
  output logic cal_dual_o,
  output logic [1:0] cal_wait_o,
  output logic [2:0] dac_start_value_o,
  output logic cal_busy_o,
  output logic cal_store_a_o,
  output logic cal_store_b_o
);

  typedef enum logic {BUS_IDLE, BUS_ACK} lbpc_bus_e;
  typedef enum logic [1:0] {CAL_IDLE, CAL_RUN, CAL_STORE} lbpc_cal_e;

  localparam logic [lbpc_pkg::CNT_W-1:0] LIM0 = lbpc_pkg::CNT_W'(CAL_WAIT0);
  localparam logic [lbpc_pkg::CNT_W-1:0] LIM1 = lbpc_pkg::CNT_W'(CAL_WAIT1);
  localparam logic [lbpc_pkg::CNT_W-1:0] LIM2 = lbpc_pkg::CNT_W'(CAL_WAIT2);
  localparam logic [lbpc_pkg::CNT_W-1:0] LIM3 = lbpc_pkg::CNT_W'(CAL_WAIT3);

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave

  lbpc_bus_e bus_state;
  lbpc_bus_e next_bus_state;
  logic [lbpc_pkg::DATA_W-1:0] next_readdata;
  logic next_waitrequest;
  logic [lbpc_pkg::IDX_W-1:0] idx;
  logic [lbpc_pkg::REG_W-1:0] rd_byte;
  logic [lbpc_pkg::REG_W-1:0] wr_byte;
  logic commit_wr;
  logic start_bit;
  logic last_tgt_a;
  logic last_tgt_b;
  lbpc_cal_e cal_state;

  assign idx = avs_address_i[lbpc_pkg::ADDR_W-1:lbpc_pkg::IDX_LSB];
  assign wr_byte = avs_writedata_i[lbpc_pkg::REG_W-1:0];
  // Write lands on the edge where waitrequest is seen low
  assign commit_wr = (bus_state == BUS_ACK) && avs_write_i && avs_byteenable_i[0];

  // Read multiplexer, unmapped words read zero
  always_comb begin
    rd_byte = '0;
    case (idx)
      lbpc_pkg::IDX_SWING: rd_byte = {pre_swing_o, rx_swing_o, tx_swing_o};
      lbpc_pkg::IDX_CURRENT: rd_byte = {pre_current_o, rx_current_o, tx_current_o};
      lbpc_pkg::IDX_BW: rd_byte = loop_bandwidth_factor_o;
      lbpc_pkg::IDX_CAL: begin
        rd_byte[lbpc_pkg::CAL_START_BIT] = start_bit;
        rd_byte[lbpc_pkg::CAL_DUAL_BIT] = cal_dual_o;
        rd_byte[lbpc_pkg::WAIT_HI:lbpc_pkg::WAIT_LO] = cal_wait_o;
        rd_byte[lbpc_pkg::CAL_RSVD_BIT] = 1'b0;
        rd_byte[lbpc_pkg::DAC_HI:lbpc_pkg::DAC_LO] = dac_start_value_o;
      end
      lbpc_pkg::IDX_STATUS: begin
        rd_byte[lbpc_pkg::ST_BUSY_BIT] = cal_busy_o;
        rd_byte[lbpc_pkg::ST_TGT_A_BIT] = last_tgt_a;
        rd_byte[lbpc_pkg::ST_TGT_B_BIT] = last_tgt_b;
      end
      default: rd_byte = '0;
    endcase
  end

  // One wait state, then a single cycle with waitrequest low
  always_comb begin
    next_bus_state = bus_state;
    next_waitrequest = 1'b1;
    next_readdata = avs_readdata_o;
    case (bus_state)
      BUS_IDLE: begin
        if (avs_read_i || avs_write_i) begin
          next_bus_state = BUS_ACK;
          next_waitrequest = 1'b0;
          next_readdata = {{(lbpc_pkg::DATA_W - lbpc_pkg::REG_W){1'b0}}, rd_byte};
        end
      end
      BUS_ACK: begin
        next_bus_state = BUS_IDLE;
      end
      default: next_bus_state = BUS_IDLE;
    endcase
  end

  // Bus state registers
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bus_state <= BUS_IDLE;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= '0;
    end else if (ce_i) begin
      bus_state <= next_bus_state;
      avs_waitrequest_o <= next_waitrequest;
      avs_readdata_o <= next_readdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  logic [1:0] next_pre_swing;
  logic [2:0] next_rx_swing;
  logic [2:0] next_tx_swing;
  logic [1:0] next_pre_current;
  logic [2:0] next_rx_current;
  logic [2:0] next_tx_current;
  logic [7:0] next_bw;
  logic next_start_bit;
  logic next_dual;
  logic [1:0] next_wait;
  logic [2:0] next_dac;
  logic start_req;

  // Start wanted on a 0 to 1 write of the start bit while idle
  assign start_req = commit_wr && (idx == lbpc_pkg::IDX_CAL)
                     && wr_byte[lbpc_pkg::CAL_START_BIT] && !start_bit
                     && (cal_state == CAL_IDLE);

  // Field updates from committed writes
  always_comb begin
    next_pre_swing = pre_swing_o;
    next_rx_swing = rx_swing_o;
    next_tx_swing = tx_swing_o;
    next_pre_current = pre_current_o;
    next_rx_current = rx_current_o;
    next_tx_current = tx_current_o;
    next_bw = loop_bandwidth_factor_o;
    next_start_bit = start_bit;
    next_dual = cal_dual_o;
    next_wait = cal_wait_o;
    next_dac = dac_start_value_o;
    if (commit_wr) begin
      case (idx)
        lbpc_pkg::IDX_SWING: begin
          next_pre_swing = wr_byte[lbpc_pkg::PRE_HI:lbpc_pkg::PRE_LO];
          next_rx_swing = wr_byte[lbpc_pkg::RX_HI:lbpc_pkg::RX_LO];
          next_tx_swing = wr_byte[lbpc_pkg::TX_HI:lbpc_pkg::TX_LO];
        end
        lbpc_pkg::IDX_CURRENT: begin
          next_pre_current = wr_byte[lbpc_pkg::PRE_HI:lbpc_pkg::PRE_LO];
          next_rx_current = wr_byte[lbpc_pkg::RX_HI:lbpc_pkg::RX_LO];
          next_tx_current = wr_byte[lbpc_pkg::TX_HI:lbpc_pkg::TX_LO];
        end
        lbpc_pkg::IDX_BW: begin
          next_bw = wr_byte;
        end
        lbpc_pkg::IDX_CAL: begin
          next_start_bit = wr_byte[lbpc_pkg::CAL_START_BIT];
          next_dual = wr_byte[lbpc_pkg::CAL_DUAL_BIT];
          next_wait = wr_byte[lbpc_pkg::WAIT_HI:lbpc_pkg::WAIT_LO];
          next_dac = wr_byte[lbpc_pkg::DAC_HI:lbpc_pkg::DAC_LO];
        end
        default: next_bw = loop_bandwidth_factor_o;
      endcase
    end
  end

  // Field registers with documented defaults
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pre_swing_o <= lbpc_pkg::PRE_SWING_RST;
      rx_swing_o <= lbpc_pkg::RX_SWING_RST;
      tx_swing_o <= lbpc_pkg::TX_SWING_RST;
      pre_current_o <= lbpc_pkg::PRE_CUR_RST;
      rx_current_o <= lbpc_pkg::RX_CUR_RST;
      tx_current_o <= lbpc_pkg::TX_CUR_RST;
      loop_bandwidth_factor_o <= lbpc_pkg::BW_RST;
      start_bit <= 1'b0;
      cal_dual_o <= 1'b0;
      cal_wait_o <= lbpc_pkg::WAIT_RST;
      dac_start_value_o <= lbpc_pkg::DAC_RST;
    end else if (ce_i) begin
      pre_swing_o <= next_pre_swing;
      rx_swing_o <= next_rx_swing;
      tx_swing_o <= next_tx_swing;
      pre_current_o <= next_pre_current;
      rx_current_o <= next_rx_current;
      tx_current_o <= next_tx_current;
      loop_bandwidth_factor_o <= next_bw;
      start_bit <= next_start_bit;
      cal_dual_o <= next_dual;
      cal_wait_o <= next_wait;
      dac_start_value_o <= next_dac;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reference clock synchroniser and tick

  logic ref_meta;
  logic ref_sync;
  logic ref_prev;
  logic ref_tick;

  // Rising edge of the synchronised reference clock
  assign ref_tick = ref_sync && !ref_prev;

  // Two flops, then a delay flop for edge detect
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ref_meta <= 1'b0;
      ref_sync <= 1'b0;
      ref_prev <= 1'b0;
    end else if (ce_i) begin
      ref_meta <= ref_clk_i;
      ref_sync <= ref_meta;
      ref_prev <= ref_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Calibration sequencer

  lbpc_cal_e next_cal_state;
  logic [lbpc_pkg::CNT_W-1:0] limit_sel;
  logic timer_done;
  logic next_busy;
  logic next_store_a;
  logic next_store_b;
  logic next_tgt_a;
  logic next_tgt_b;

  // Duration from the wait code written along with the start bit
  always_comb begin
    case (next_wait)
      lbpc_pkg::WAIT_CODE0: limit_sel = LIM0;
      lbpc_pkg::WAIT_CODE1: limit_sel = LIM1;
      lbpc_pkg::WAIT_CODE2: limit_sel = LIM2;
      default: limit_sel = LIM3;
    endcase
  end

  lbpc_cal_timer #(
    .CNT_W(lbpc_pkg::CNT_W)
  ) u_timer (
    .clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .start_i(start_req),
    .tick_i(ref_tick),
    .limit_i(limit_sel),
    .done_o(timer_done)
  );

  // Run until the timer ends, then one store pulse
  always_comb begin
    next_cal_state = cal_state;
    next_store_a = 1'b0;
    next_store_b = 1'b0;
    next_tgt_a = last_tgt_a;
    next_tgt_b = last_tgt_b;
    case (cal_state)
      CAL_IDLE: begin
        if (start_req) begin
          next_cal_state = CAL_RUN;
        end
      end
      CAL_RUN: begin
        if (timer_done) begin
          next_cal_state = CAL_STORE;
          next_store_a = cal_dual_o || !freq_select_i;
          next_store_b = cal_dual_o || freq_select_i;
          next_tgt_a = next_store_a;
          next_tgt_b = next_store_b;
        end
      end
      CAL_STORE: begin
        next_cal_state = CAL_IDLE;
      end
      default: next_cal_state = CAL_IDLE;
    endcase
    next_busy = (next_cal_state != CAL_IDLE);
  end

  // Sequencer registers
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cal_state <= CAL_IDLE;
      cal_busy_o <= 1'b0;
      cal_store_a_o <= 1'b0;
      cal_store_b_o <= 1'b0;
      last_tgt_a <= 1'b0;
      last_tgt_b <= 1'b0;
    end else if (ce_i) begin
      cal_state <= next_cal_state;
      cal_busy_o <= next_busy;
      cal_store_a_o <= next_store_a;
      cal_store_b_o <= next_store_b;
      last_tgt_a <= next_tgt_a;
      last_tgt_b <= next_tgt_b;
    end
  end

endmodule

`default_nettype wire

// File: testbench/lbpc_assertions.sv
// Checker for field, bus and calibration behaviour of the register bank.
// Assumes it is bound to lbpc_regs and sees only its ports.
`default_nettype none
module lbpc_assertions (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic freq_select_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic [1:0] pre_swing_o,
  input wire logic [2:0] rx_swing_o,
  input wire logic [2:0] tx_swing_o,
  input wire logic [1:0] pre_current_o,
  input wire logic [2:0] rx_current_o,
  input wire logic [2:0] tx_current_o,
  input wire logic [7:0] loop_bandwidth_factor_o,
  input wire logic cal_dual_o,
  input wire logic [1:0] cal_wait_o,
  input wire logic [2:0] dac_start_value_o,
  input wire logic cal_busy_o,
  input wire logic cal_store_a_o,
  input wire logic cal_store_b_o
);
  logic wr_ok;
  logic st_any;
  // Committed lane-0 write and any store pulse
  assign wr_ok = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
  assign st_any = cal_store_a_o || cal_store_b_o;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  ////////////////////////////////////////
  a_reset_fields: assert property ($rose(rst_b_i) |-> {pre_swing_o, rx_swing_o, tx_swing_o,
    pre_current_o, rx_current_o, tx_current_o} == 16'he165)
    else $error("field defaults wrong after reset");
  a_reset_cal: assert property ($rose(rst_b_i) |-> loop_bandwidth_factor_o == 8'h86
    && {cal_dual_o, cal_wait_o, dac_start_value_o} == 6'h05)
    else $error("calibration defaults wrong after reset");
  a_swing_write: assert property (wr_ok && avs_address_i == 8'h60 |=>
    {pre_swing_o, rx_swing_o, tx_swing_o} == $past(avs_writedata_i[7:0]))
    else $error("swing fields not written");
  a_current_write: assert property (wr_ok && avs_address_i == 8'h64 |=>
    {pre_current_o, rx_current_o, tx_current_o} == $past(avs_writedata_i[7:0]))
    else $error("current fields not written");
  a_bw_write: assert property (wr_ok && avs_address_i == 8'h68 |=>
    loop_bandwidth_factor_o == $past(avs_writedata_i[7:0]))
    else $error("bandwidth factor not written");
  a_fields_hold: assert property (!wr_ok |=> $stable({pre_swing_o, rx_swing_o,
    tx_swing_o, pre_current_o, rx_current_o, tx_current_o, loop_bandwidth_factor_o}))
    else $error("field changed without write");
  a_rsvd_zero: assert property (!avs_waitrequest_o && avs_read_i |->
    avs_readdata_o[31:8] == 24'h0 && !(avs_address_i == 8'h6c && avs_readdata_o[3]))
    else $error("reserved read bits not zero");
  a_start_cause: assert property ($rose(cal_busy_o) |-> $past(wr_ok &&
    avs_address_i == 8'h6c && avs_writedata_i[7]))
    else $error("calibration started without start write");
  a_busy_min: assert property ($rose(cal_busy_o) |-> cal_busy_o [*8])
    else $error("calibration ended too early");
  a_store_end: assert property (st_any |-> cal_busy_o ##1 !cal_busy_o && !st_any)
    else $error("store pulse not at calibration end");
  a_store_target: assert property (st_any |->
    cal_store_a_o == $past(cal_dual_o || !freq_select_i)
    && cal_store_b_o == $past(cal_dual_o || freq_select_i))
    else $error("store targets disagree with dual select");
  c_both: cover property (cal_store_a_o && cal_store_b_o);
  c_only_b: cover property (cal_store_b_o && !cal_store_a_o);
  c_cal_write: cover property (wr_ok && avs_address_i == 8'h6c);
endmodule
bind lbpc_regs lbpc_assertions lbpc_assertions_inst (.*);
`default_nettype wire

// File: testbench/lbpc_host.sv
// Host model: bus master tasks, reference clock and host-side settings.
// Assumes one caller at a time and test_done in the bench top.
`default_nettype none
module lbpc_host (
  input wire logic core_clk_i,
  input wire logic wait_i,
  input wire logic [31:0] rdata_i,
  output logic [7:0] addr_o,
  output logic rd_o,
  output logic wr_o,
  output logic [31:0] wdata_o,
  output logic [3:0] be_o,
  output logic ref_clk_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus and a free 10 MHz reference of unrelated phase
  initial begin
    addr_o = 8'h00;
    rd_o = 1'b0;
    wr_o = 1'b0;
    wdata_o = 32'h0;
    be_o = 4'h1;
    ref_clk_o = 1'b0;
    #7;
    forever #50 ref_clk_o = ~ref_clk_o;
  end
  // One access, held until waitrequest is sampled low
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge core_clk_i);
    addr_o <= a;
    rd_o <= !w;
    wr_o <= w;
    wdata_o <= {24'h0, d};
    be_o <= be;
    do begin
      @(posedge core_clk_i);
      n++;
      if (n > 50) lbpc_regs_tb.test_done(1'b1);
    end while (wait_i !== 1'b0);
    q = rdata_i;
    rd_o <= 1'b0;
    wr_o <= 1'b0;
  endtask
  // Clear start and wait code, then set start with the wanted code
  task automatic cal_go(input logic [7:0] v);
    logic [31:0] q;
    acc(1'b1, 8'h6c, v & 8'h4f, 4'h1, q);
    acc(1'b1, 8'h6c, v | 8'h80, 4'h1, q);
  endtask
  // Bandwidth factor for a 10 MHz reference, rounded
  task automatic set_bw();
    real f;
    logic [31:0] q;
    f = 174.0 + 16.0 * $ln(10.0 / 7.126) / $ln(2.0);
    acc(1'b1, 8'h68, 8'($rtoi(f + 0.5)), 4'h1, q);
  endtask
  // Suggested buffer settings per band
  task automatic set_band(input logic up);
    logic [31:0] q;
    acc(1'b1, 8'h60, {2'h0, 3'h2, up ? 3'h0 : 3'h4}, 4'h1, q);
    acc(1'b1, 8'h64, {2'h0, 3'h4, up ? 3'h5 : 3'h2}, 4'h1, q);
  endtask
endmodule
`default_nettype wire

// File: testbench/lbpc_regs_tb.sv
// Self-checking bench for the LO buffer and calibration register bank.
// Assumes shortened calibration counts and a 10 MHz reference from the host.
`default_nettype none
module lbpc_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int WT [4] = '{4, 7, 10, 13};
  logic core_clk_i, rst_b_i, ce_i, freq_select_i, rd_s, wr_s, wait_s, ref_clk;
  logic [7:0] adr, bw;
  logic [31:0] wdat, rdat;
  logic [3:0] be;
  logic [1:0] pre_sw, pre_cur, cwait;
  logic [2:0] rx_sw, tx_sw, rx_cur, tx_cur, dac;
  logic dual, busy, st_a, st_b;
  int err_total, num_checks;
  lbpc_regs #(.CAL_WAIT0(WT[0]), .CAL_WAIT1(WT[1]), .CAL_WAIT2(WT[2]), .CAL_WAIT3(WT[3]))
    lbpc_regs_inst (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
    .avs_address_i(adr), .avs_read_i(rd_s), .avs_write_i(wr_s), .avs_writedata_i(wdat),
    .avs_byteenable_i(be), .avs_readdata_o(rdat), .avs_waitrequest_o(wait_s),
    .ref_clk_i(ref_clk), .freq_select_i(freq_select_i), .pre_swing_o(pre_sw),
    .rx_swing_o(rx_sw), .tx_swing_o(tx_sw), .pre_current_o(pre_cur), .rx_current_o(rx_cur),
    .tx_current_o(tx_cur), .loop_bandwidth_factor_o(bw), .cal_dual_o(dual),
    .cal_wait_o(cwait), .dac_start_value_o(dac), .cal_busy_o(busy), .cal_store_a_o(st_a),
    .cal_store_b_o(st_b));
  lbpc_host lbpc_host_inst (.core_clk_i(core_clk_i), .wait_i(wait_s), .rdata_i(rdat),
    .addr_o(adr), .rd_o(rd_s), .wr_o(wr_s), .wdata_o(wdat), .be_o(be), .ref_clk_o(ref_clk));
  // 50 MHz clock
  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic test_done(input logic hang);
    if (hang) err_total++;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] e = 4'h1);
    logic [31:0] q;
    lbpc_host_inst.acc(1'b1, a, d, e, q);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    lbpc_host_inst.acc(1'b0, a, 8'h00, 4'h1, q);
    chk($sformatf("reg %h", a), q, e);
  endtask
  // Follow a running calibration to its end, noting store pulses
  task automatic run(output int n, output logic a, output logic b);
    n = 0;
    a = 1'b0;
    b = 1'b0;
    @(posedge core_clk_i);
    while (busy === 1'b1) begin
      @(posedge core_clk_i);
      a |= st_a;
      b |= st_b;
      n++;
      if (n > 300) test_done(1'b1);
    end
  endtask
  ////////////////////////////////////////
  task automatic t_fields();
    logic [7:0] v [3] = '{8'h00, 8'hff, 8'h5a};
    foreach (v[i]) begin
      wr(8'h60, v[i]);
      wr(8'h64, v[i] ^ 8'hff);
      wr(8'h68, v[i] ^ 8'h3c);
      chk("swing", {pre_sw, rx_sw, tx_sw}, v[i]);
      chk("current", {pre_cur, rx_cur, tx_cur}, v[i] ^ 8'hff);
      rchk(8'h68, v[i] ^ 8'h3c);
    end
    wr(8'h68, 8'h11, 4'h0);
    rchk(8'h68, 32'h66);
    wr(8'h40, 8'hff);
    rchk(8'h40, 32'h0);
    rchk(8'h60, 32'h5a);
    wr(8'h6c, 8'h7f);
    rchk(8'h6c, 32'h77);
    chk("cal fields", {dual, cwait, dac}, 6'h3f);
    chk("idle", busy, 0);
    $display("test fields done");
  endtask
  task automatic t_cal(input logic [1:0] c);
    int n;
    logic a, b, dl;
    dl = (c == 2'h2);
    freq_select_i <= c[0];
    lbpc_host_inst.cal_go({1'b0, dl, c, 4'h4});
    run(n, a, b);
    chk("duration", n >= WT[c] * 5 - 3 && n <= WT[c] * 5 + 9, 1);
    chk("targets", {b, a}, {dl | c[0], dl | !c[0]});
    rchk(8'hc0, {29'h0, dl | c[0], dl | !c[0], 1'b0});
    $display("test calibration %0d done", c);
  endtask
  task automatic t_refuse();
    int n;
    logic a, b;
    lbpc_host_inst.cal_go(8'h30);
    wr(8'h6c, 8'h30);
    wr(8'h6c, 8'hb0);
    run(n, a, b);
    rchk(8'h6c, 32'hb0);
    wr(8'h6c, 8'hb0);
    repeat (8) @(posedge core_clk_i);
    chk("no restart", busy, 0);
    $display("test refuse done");
  endtask
  task automatic t_reset_mid();
    lbpc_host_inst.cal_go(8'h00);
    repeat (5) @(posedge core_clk_i);
    rst_b_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    chk("busy", busy, 0);
    chk("swing", {pre_sw, rx_sw, tx_sw}, 8'he1);
    rchk(8'h64, 32'h65);
    rchk(8'h68, 32'h86);
    rchk(8'h6c, 32'h05);
    $display("test reset done");
  endtask
  task automatic t_host();
    lbpc_host_inst.set_band(1'b0);
    @(posedge core_clk_i);
    chk("lower", {tx_sw, tx_cur}, 6'h22);
    lbpc_host_inst.set_band(1'b1);
    lbpc_host_inst.set_bw();
    @(posedge core_clk_i);
    chk("upper", {rx_sw, rx_cur, tx_sw, tx_cur}, 12'h505);
    chk("bw", bw, 8'hb6);
    $display("test host settings done");
  endtask
  ////////////////////////////////////////
  initial begin
    rst_b_i = 1'b0;
    ce_i = 1'b1;
    freq_select_i = 1'b0;
    err_total = 0;
    num_checks = 0;
    repeat (8) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    t_reset_mid();
    t_fields();
    for (int c = 0; c < 4; c++) t_cal(2'(c));
    t_refuse();
    t_host();
    test_done(1'b0);
  end
endmodule
`default_nettype wire
